// File: logic/lcd_cmd_map.svh
// Command codes, field positions and reset values of the command decoder
`ifndef LCD_CMD_MAP_SVH
`define LCD_CMD_MAP_SVH
`define CMD_BIAS_9 8'ha2
`define CMD_BIAS_7 8'ha3
`define CMD_ALL_NORMAL 8'ha4
`define CMD_ALL_ON 8'ha5
`define CMD_DISP_OFF 8'hae
`define CMD_DISP_ON 8'haf
`define CMD_IND_OFF 8'hac
`define CMD_IND_ON 8'had
`define CMD_CONTRAST_MODE 8'h81
`define CMD_RMW 8'he0
`define CMD_RMW_END 8'hee
`define CMD_SOFT_RESET 8'he2
`define CMD_NOP 8'he3
`define SCAN_NIBBLE 4'hc
`define SCAN_DIR_BIT 3
`define SUPPLY_PREFIX 5'b00101
`define RATIO_PREFIX 5'b00100
`define COL_HI_NIBBLE 4'h1
`define COL_LO_NIBBLE 4'h0
`define COL_WIDTH 8
`define RST_RATIO 3'h0
`define RST_CONTRAST 6'h00
`define RST_IND 2'h0
`define RST_SUPPLY 3'h0
`endif

// File: logic/lcd_cmd_pkg.sv
// Types used by the controller end of the command link
package lcd_cmd_pkg;
    typedef enum logic [1:0] {
        PEND_NONE = 2'b00,
        PEND_CONTRAST = 2'b01,
        PEND_IND = 2'b11
    } pend_t;
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_SLEEP = 2'b01,
        PWR_STANDBY = 2'b11
    } pwr_t;
endpackage

// File: logic/lcd_cmd_if.sv
// Byte port between host and display controller
`timescale 1ns/1ps
interface lcd_cmd_if;
    logic wr_stb;
    logic command_data_select;
    logic rd_stb;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport device (
        input wr_stb,
        input command_data_select,
        input rd_stb,
        input wdata,
        output rdata
    );
    modport host (
        output wr_stb,
        output command_data_select,
        output rd_stb,
        output wdata,
        input rdata
    );
endinterface

// File: logic/lcd_cmd_device.sv
// Display controller end: command decoder and setting registers
// Function
// - 0xA2/0xA3 pick bias, valid with follower on
// - RMW mode: reads hold column, writes increment
// - End restores saved column, leaves RMW
// - Host sends no column set in RMW
// - Soft reset restores registers, keeps memory
// - Host uses hardware reset at power-up
// - 0xCx byte bit3 selects common direction
// - 00101 byte bits enable booster, regulator, follower
// - 00100 byte stores regulator gain code
// - After 0x81 only contrast value accepted
// - Contrast value low six bits stored
// - 0xAC indicator off, 0xAD on pending
// - After 0xAD only indicator value accepted
// - Indicator value stores two blink bits
// - Indicator changed only by own commands and soft reset
// - All-on while display off enters low power
// - Indicator off gives sleep, on standby
// - Memory kept and served in low power
// - All-on off form leaves low power
// - 0xA5 forces all pixels on while the display runs
// - Soft reset in standby moves to sleep
// - Display-off output low in low power
`timescale 1ns/1ps
`include "lcd_cmd_map.svh"
module lcd_cmd_device #(
    parameter int COLS = 132
) (
    input wire logic REF_CLK,
    input wire logic NRST,
    lcd_cmd_if.device BUS,
    output logic BIAS_SEVENTH,
    output logic BOOSTER_ON,
    output logic REGULATOR_ON,
    output logic FOLLOWER_ON,
    output logic [2:0] REGULATOR_GAIN_RATIO,
    output logic [5:0] LCD_CONTRAST_LEVEL,
    output logic [1:0] INDICATOR_BLINK_SELECT,
    output logic COMMON_SCAN_REVERSE,
    output logic DISPLAY_ON,
    output logic ALL_PIXELS_ON,
    output logic RMW_ACTIVE,
    output logic [7:0] COLUMN,
    output logic [1:0] POWER_STATE,
    output logic DISPLAY_OFF_OUT_N
);
    logic [7:0] wdata;
    logic cmd_stb;
    logic data_wr;
    logic data_rd;
    logic bias_q;
    logic [2:0] supply_q;
    logic [2:0] ratio_q;
    logic [5:0] contrast_q;
    logic [1:0] ind_q;
    logic scan_q;
    logic disp_on_q;
    logic all_on_q;
    logic rmw_q;
    logic [7:0] col_q;
    logic [7:0] col_save_q;
    logic [7:0] mem_q [COLS];
    logic [7:0] rdata_q;
    lcd_cmd_pkg::pend_t pend_q;
    lcd_cmd_pkg::pwr_t pwr_q;
    logic soft_rst;

    // Strobe decode; both strobes are same-clock pulses from the host
    assign wdata = BUS.wdata;
    assign cmd_stb = BUS.wr_stb && !BUS.command_data_select;
    assign data_wr = BUS.wr_stb && BUS.command_data_select;
    assign data_rd = BUS.rd_stb && BUS.command_data_select;
    assign soft_rst = cmd_stb && pend_q == lcd_cmd_pkg::PEND_NONE
        && wdata == `CMD_SOFT_RESET;

    // Pending second byte of two-byte commands
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
            pend_q <= lcd_cmd_pkg::PEND_NONE;
        else if (cmd_stb)
        begin
            case (pend_q)
                lcd_cmd_pkg::PEND_NONE:
                    if (wdata == `CMD_CONTRAST_MODE)
                        pend_q <= lcd_cmd_pkg::PEND_CONTRAST;
                    else if (wdata == `CMD_IND_ON)
                        pend_q <= lcd_cmd_pkg::PEND_IND;
                lcd_cmd_pkg::PEND_CONTRAST: pend_q <= lcd_cmd_pkg::PEND_NONE;
                lcd_cmd_pkg::PEND_IND: pend_q <= lcd_cmd_pkg::PEND_NONE;
                default: pend_q <= lcd_cmd_pkg::PEND_NONE;
            endcase
        end
    end

    // Value bytes of two-byte commands
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST || soft_rst)
        begin
            contrast_q <= `RST_CONTRAST;
            ind_q <= `RST_IND;
        end
        else if (cmd_stb && pend_q == lcd_cmd_pkg::PEND_CONTRAST)
            contrast_q <= wdata[5:0];
        else if (cmd_stb && pend_q == lcd_cmd_pkg::PEND_IND)
            ind_q <= wdata[1:0];
        else if (cmd_stb && pend_q == lcd_cmd_pkg::PEND_NONE && wdata == `CMD_IND_OFF)
            ind_q <= `RST_IND;
    end

    // One-byte settings; unknown codes fall through untouched
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST || soft_rst)
        begin
            bias_q <= 1'b0;
            supply_q <= `RST_SUPPLY;
            ratio_q <= `RST_RATIO;
            scan_q <= 1'b0;
            disp_on_q <= 1'b0;
            all_on_q <= 1'b0;
        end
        else if (cmd_stb && pend_q == lcd_cmd_pkg::PEND_NONE)
        begin
            if (wdata == `CMD_BIAS_9 || wdata == `CMD_BIAS_7)
                bias_q <= wdata[0];
            else if (wdata == `CMD_ALL_NORMAL || wdata == `CMD_ALL_ON)
                all_on_q <= wdata[0];
            else if (wdata == `CMD_DISP_OFF || wdata == `CMD_DISP_ON)
                disp_on_q <= wdata[0];
            else if (wdata[7:4] == `SCAN_NIBBLE)
                scan_q <= wdata[`SCAN_DIR_BIT];
            else if (wdata[7:3] == `SUPPLY_PREFIX)
                supply_q <= wdata[2:0];
            else if (wdata[7:3] == `RATIO_PREFIX)
                ratio_q <= wdata[2:0];
        end
    end

    // Power save: all-on while off enters, all-on normal leaves
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
            pwr_q <= lcd_cmd_pkg::PWR_RUN;
        else if (soft_rst && pwr_q == lcd_cmd_pkg::PWR_STANDBY)
            pwr_q <= lcd_cmd_pkg::PWR_SLEEP;
        else if (cmd_stb && pend_q == lcd_cmd_pkg::PEND_NONE)
        begin
            if (wdata == `CMD_ALL_ON && !disp_on_q)
                pwr_q <= (ind_q == `RST_IND) ? lcd_cmd_pkg::PWR_SLEEP
                    : lcd_cmd_pkg::PWR_STANDBY;
            else if (wdata == `CMD_ALL_NORMAL)
                pwr_q <= lcd_cmd_pkg::PWR_RUN;
        end
    end

    // Read-modify-write mode and saved column
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST || soft_rst)
        begin
            rmw_q <= 1'b0;
            col_save_q <= 8'h00;
        end
        else if (cmd_stb && pend_q == lcd_cmd_pkg::PEND_NONE && wdata == `CMD_RMW)
        begin
            rmw_q <= 1'b1;
            col_save_q <= col_q;
        end
        else if (cmd_stb && pend_q == lcd_cmd_pkg::PEND_NONE && wdata == `CMD_RMW_END)
            rmw_q <= 1'b0;
    end

    // Column pointer: set, restore, auto-increment capped at last column
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST || soft_rst)
            col_q <= 8'h00;
        else if (cmd_stb && pend_q == lcd_cmd_pkg::PEND_NONE && wdata == `CMD_RMW_END)
            col_q <= col_save_q;
        else if (cmd_stb && pend_q == lcd_cmd_pkg::PEND_NONE
            && wdata[7:4] == `COL_HI_NIBBLE)
            col_q <= {wdata[3:0], col_q[3:0]};
        else if (cmd_stb && pend_q == lcd_cmd_pkg::PEND_NONE
            && wdata[7:4] == `COL_LO_NIBBLE)
            col_q <= {col_q[7:4], wdata[3:0]};
        else if ((data_wr || (data_rd && !rmw_q)) && col_q < 8'(COLS - 1))
            col_q <= col_q + 8'h01;
    end

    // Display memory, served in every power state
    always_ff @(posedge REF_CLK)
    begin
        if (data_wr && col_q < 8'(COLS))
            mem_q[col_q] <= wdata;
    end

    // Read data register
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
            rdata_q <= 8'h00;
        else if (data_rd)
            rdata_q <= (col_q < 8'(COLS)) ? mem_q[col_q] : 8'h00;
    end

    assign BUS.rdata = rdata_q;
    assign BIAS_SEVENTH = bias_q;
    assign BOOSTER_ON = supply_q[2];
    assign REGULATOR_ON = supply_q[1];
    assign FOLLOWER_ON = supply_q[0];
    assign REGULATOR_GAIN_RATIO = ratio_q;
    assign LCD_CONTRAST_LEVEL = contrast_q;
    assign INDICATOR_BLINK_SELECT = ind_q;
    assign COMMON_SCAN_REVERSE = scan_q;
    assign DISPLAY_ON = disp_on_q && pwr_q == lcd_cmd_pkg::PWR_RUN;
    assign ALL_PIXELS_ON = all_on_q && pwr_q == lcd_cmd_pkg::PWR_RUN;
    assign RMW_ACTIVE = rmw_q;
    assign COLUMN = col_q;
    assign POWER_STATE = pwr_q;
    assign DISPLAY_OFF_OUT_N = pwr_q == lcd_cmd_pkg::PWR_RUN;
endmodule

// File: logic/lcd_cmd_host.sv
// Host end: APB slave that issues command and data bytes to the controller
`timescale 1ns/1ps
`include "lcd_cmd_map.svh"
module lcd_cmd_host (
    input wire logic REF_CLK,
    input wire logic NRST,
    lcd_cmd_if.host BUS,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    localparam logic [11:0] OFF_CMD = 12'h000;
    localparam logic [11:0] OFF_DATA = 12'h004;
    localparam logic [11:0] OFF_RDATA = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    logic access;
    logic wr_q;
    logic sel_q;
    logic rd_q;
    logic [7:0] wdata_q;
    logic [7:0] last_cmd_q;
    logic pend_q;
    logic rmw_q;
    logic rd_pend_q;
    logic [31:0] prdata_q;
    logic [7:0] rbyte_q;
    logic refused;
    logic [7:0] b;

    assign access = PSEL && PENABLE;
    assign b = PWDATA[7:0];

    // Byte strobes, one cycle per accepted OFF_CMD/OFF_DATA write or OFF_RDATA read
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            sel_q <= 1'b0;
            wdata_q <= 8'h00;
        end
        else
        begin
            wr_q <= access && PWRITE && (PADDR == OFF_CMD || PADDR == OFF_DATA)
                && !refused;
            rd_q <= access && !PWRITE && PADDR == OFF_RDATA;
            if (access && PWRITE && (PADDR == OFF_CMD || PADDR == OFF_DATA))
            begin
                sel_q <= PADDR == OFF_DATA;
                wdata_q <= b;
            end
            else if (access && !PWRITE && PADDR == OFF_RDATA)
                sel_q <= 1'b1; // Reads always target display memory
        end
    end

    // Tracks two-byte sequences and RMW so the value byte goes next
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
        begin
            pend_q <= 1'b0;
            rmw_q <= 1'b0;
            last_cmd_q <= 8'h00;
        end
        else if (access && PWRITE && PADDR == OFF_CMD)
        begin
            last_cmd_q <= b;
            pend_q <= !pend_q && (b == `CMD_CONTRAST_MODE || b == `CMD_IND_ON);
            if (!pend_q && b == `CMD_RMW)
                rmw_q <= 1'b1;
            else if (!pend_q && (b == `CMD_RMW_END || b == `CMD_SOFT_RESET))
                rmw_q <= 1'b0;
        end
    end

    // Read data: status or last byte returned by the controller
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
            rd_pend_q <= 1'b0;
        else
            rd_pend_q <= rd_q;
    end

    // Byte of the previous display read, kept apart from status reads
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
            rbyte_q <= 8'h00;
        else if (rd_pend_q)
            rbyte_q <= BUS.rdata;
    end

    // Read word loaded in the setup cycle, stands through the access phase
    always_ff @(posedge REF_CLK)
    begin
        if (!NRST)
            prdata_q <= 32'h0000_0000;
        else if (PSEL && !PENABLE && !PWRITE)
        begin
            if (PADDR == OFF_STATUS)
                prdata_q <= {22'h0, rmw_q, pend_q, last_cmd_q};
            else if (PADDR == OFF_RDATA)
                prdata_q <= {24'h0, rbyte_q};
            else
                prdata_q <= 32'h0000_0000;
        end
    end

    // Column set during RMW and unmapped addresses are refused; refused bytes stay here
    assign refused = PWRITE && PADDR == OFF_CMD && rmw_q && !pend_q
        && (b[7:4] == `COL_HI_NIBBLE || b[7:4] == `COL_LO_NIBBLE);
    assign PSLVERR = access && (refused || !(PADDR == OFF_CMD || PADDR == OFF_DATA
        || PADDR == OFF_RDATA || PADDR == OFF_STATUS));
    assign PREADY = 1'b1;
    assign PRDATA = prdata_q;
    assign BUS.wr_stb = wr_q;
    assign BUS.rd_stb = rd_q;
    assign BUS.command_data_select = sel_q;
    assign BUS.wdata = wdata_q;
endmodule

// File: bench/lcd_cmd_assertions.sv
// Concurrent checks on the command link and the controller settings
`timescale 1ns/1ps
module lcd_cmd_assertions (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic wr_stb,
    input wire logic command_data_select,
    input wire logic rd_stb,
    input wire logic [7:0] wdata,
    input wire logic BIAS_SEVENTH,
    input wire logic BOOSTER_ON,
    input wire logic REGULATOR_ON,
    input wire logic FOLLOWER_ON,
    input wire logic [2:0] REGULATOR_GAIN_RATIO,
    input wire logic [5:0] LCD_CONTRAST_LEVEL,
    input wire logic [1:0] INDICATOR_BLINK_SELECT,
    input wire logic COMMON_SCAN_REVERSE,
    input wire logic DISPLAY_ON,
    input wire logic RMW_ACTIVE,
    input wire logic [7:0] COLUMN,
    input wire logic [1:0] POWER_STATE,
    input wire logic DISPLAY_OFF_OUT_N
);
    logic [1:0] pend_q;
    logic cmd;
    logic op;
    // Command strobe, and a command not swallowed as a value byte
    assign cmd = wr_stb && !command_data_select;
    assign op = cmd && pend_q == 2'h0;
    // Pending value byte: 1 contrast, 2 indicator
    always_ff @(posedge REF_CLK)
        if (!NRST)
            pend_q <= 2'h0;
        else if (cmd)
            pend_q <= !op ? 2'h0 : wdata == 8'h81 ? 2'h1 : wdata == 8'had ? 2'h2 : 2'h0;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    bias_sel_a: assert property (op && wdata[7:1] == 7'h51
        |=> BIAS_SEVENTH == $past(wdata[0])) else $error("bias select wrong");
    scan_dir_a: assert property (op && wdata[7:4] == 4'hc
        |=> COMMON_SCAN_REVERSE == $past(wdata[3])) else $error("scan direction wrong");
    supply_bits_a: assert property (op && wdata[7:3] == 5'h05
        |=> {BOOSTER_ON, REGULATOR_ON, FOLLOWER_ON} == $past(wdata[2:0]))
        else $error("supply bits wrong");
    gain_code_a: assert property (op && wdata[7:3] == 5'h04
        |=> REGULATOR_GAIN_RATIO == $past(wdata[2:0])) else $error("gain code wrong");
    contrast_val_a: assert property (cmd && pend_q == 2'h1
        |=> LCD_CONTRAST_LEVEL == $past(wdata[5:0])) else $error("contrast wrong");
    ind_val_a: assert property (cmd && pend_q == 2'h2
        |=> INDICATOR_BLINK_SELECT == $past(wdata[1:0])) else $error("indicator wrong");
    ind_keep_a: assert property (!(cmd && (pend_q == 2'h2 || wdata == 8'hac
        || wdata == 8'he2)) |=> $stable(INDICATOR_BLINK_SELECT)) else $error("indicator moved");
    save_entry_a: assert property (op && wdata == 8'ha5 && !DISPLAY_ON
        |=> POWER_STATE == ($past(INDICATOR_BLINK_SELECT) == 2'h0 ? 2'h1 : 2'h3))
        else $error("low power entry wrong");
    save_exit_a: assert property (op && wdata == 8'ha4 |=> POWER_STATE == 2'h0)
        else $error("low power exit wrong");
    dof_level_a: assert property (DISPLAY_OFF_OUT_N == (POWER_STATE == 2'h0))
        else $error("display-off output wrong");
    rmw_hold_a: assert property (RMW_ACTIVE && rd_stb |=> $stable(COLUMN))
        else $error("column moved on read");
    soft_reset_a: assert property (op && wdata == 8'he2 |=> LCD_CONTRAST_LEVEL == 6'h00
        && !BIAS_SEVENTH && REGULATOR_GAIN_RATIO == 3'h0) else $error("soft reset wrong");
endmodule

// File: bench/tb.sv
// Self-checking bench: APB host end driving the controller end
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, err_q;
    logic bias7, boost, reg_on, fol, scan, dsp, allon, rmw, dofn;
    logic [2:0] ratio;
    logic [5:0] con;
    logic [1:0] ind, pwr;
    logic [7:0] col;
    logic [7:0] rd_byte;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    lcd_cmd_if link ();
    lcd_cmd_host u_lcd_cmd_host (.REF_CLK(clk), .NRST(nrst), .BUS(link.host), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr));
    lcd_cmd_device u_lcd_cmd_device (.REF_CLK(clk), .NRST(nrst), .BUS(link.device),
        .BIAS_SEVENTH(bias7), .BOOSTER_ON(boost), .REGULATOR_ON(reg_on), .FOLLOWER_ON(fol),
        .REGULATOR_GAIN_RATIO(ratio), .LCD_CONTRAST_LEVEL(con), .INDICATOR_BLINK_SELECT(ind),
        .COMMON_SCAN_REVERSE(scan), .DISPLAY_ON(dsp), .ALL_PIXELS_ON(allon), .RMW_ACTIVE(rmw),
        .COLUMN(col), .POWER_STATE(pwr), .DISPLAY_OFF_OUT_N(dofn));
    lcd_cmd_assertions u_lcd_cmd_assertions (.REF_CLK(clk), .NRST(nrst),
        .wr_stb(link.wr_stb), .command_data_select(link.command_data_select),
        .rd_stb(link.rd_stb), .wdata(link.wdata), .BIAS_SEVENTH(bias7), .BOOSTER_ON(boost),
        .REGULATOR_ON(reg_on), .FOLLOWER_ON(fol), .REGULATOR_GAIN_RATIO(ratio),
        .LCD_CONTRAST_LEVEL(con), .INDICATOR_BLINK_SELECT(ind), .COMMON_SCAN_REVERSE(scan),
        .DISPLAY_ON(dsp), .RMW_ACTIVE(rmw), .COLUMN(col), .POWER_STATE(pwr),
        .DISPLAY_OFF_OUT_N(dofn));
    // Clock
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // Verdict and end of run
    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_errors++;
            stop_test();
        end
    end
    // Compare and report
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer, then room for the byte to reach the controller
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        err_q = pslverr;
        rd_byte = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] d);
        apb(1'b1, 12'h000, d);
    endtask
    // Reset values, then soft reset after settings were changed
    task automatic t_soft_reset();
        chk("dof", 8'h1, dofn);
        chk("power", 8'h0, pwr);
        cmd(8'h81);
        cmd(8'h2a);
        chk("contrast", 8'h2a, con);
        cmd(8'ha3);
        cmd(8'h25);
        cmd(8'he2);
        chk("contrast", 8'h0, con);
        chk("bias", 8'h0, bias7);
        chk("ratio", 8'h0, ratio);
    endtask
    // Ratio and supply settings over every code, bias and scan, plus an undefined code
    task automatic t_settings();
        for (int i = 0; i < 8; i++)
        begin
            cmd(8'h20 | i[7:0]);
            chk("ratio", i[7:0], ratio);
            cmd(8'h28 | i[7:0]);
            chk("supply", i[7:0], {boost, reg_on, fol});
        end
        cmd(8'ha3);
        chk("bias", 8'h1, bias7);
        cmd(8'hcf);
        chk("scan", 8'h1, scan);
        cmd(8'hc7);
        chk("scan", 8'h0, scan);
        cmd(8'ha2);
        cmd(8'hd8);
        chk("bias", 8'h0, bias7);
        chk("ratio", 8'h7, ratio);
    endtask
    // Two-byte commands whose value bytes look like other commands
    task automatic t_two_byte();
        cmd(8'h81);
        cmd(8'ha3);
        chk("contrast", 8'h23, con);
        chk("bias", 8'h0, bias7);
        cmd(8'h81);
        cmd(8'hff);
        chk("contrast", 8'h3f, con);
        for (int i = 0; i < 4; i++)
        begin
            cmd(8'had);
            cmd(8'he0 | i[7:0]);
            chk("indicator", i[7:0], ind);
        end
        chk("rmw", 8'h0, rmw);
        chk("contrast", 8'h3f, con);
        cmd(8'ha3);
        cmd(8'hc8);
        chk("indicator", 8'h3, ind);
        cmd(8'hac);
        chk("indicator", 8'h0, ind);
    endtask
    // Cursor mode: reads hold, writes step, end restores
    task automatic t_rmw();
        cmd(8'h10);
        cmd(8'h05);
        chk("column", 8'h05, col);
        cmd(8'he0);
        apb(1'b0, 12'h008, 8'h00);
        chk("column", 8'h05, col);
        apb(1'b1, 12'h004, 8'h55);
        chk("column", 8'h06, col);
        cmd(8'h12);
        chk("column set refused", 8'h1, err_q);
        cmd(8'hee);
        chk("column", 8'h05, col);
        chk("rmw", 8'h0, rmw);
        apb(1'b0, 12'h008, 8'h00);
        chk("column", 8'h06, col);
        apb(1'b0, 12'h008, 8'h00);
        chk("read data", 8'h55, rd_byte);
        chk("column", 8'h07, col);
        apb(1'b1, 12'h010, 8'h00);
        chk("unmapped", 8'h1, err_q);
    endtask
    // Sleep, standby, memory access in standby, soft reset in standby
    task automatic t_power();
        cmd(8'ha5);
        chk("power", 8'h1, pwr);
        chk("dof", 8'h0, dofn);
        cmd(8'ha4);
        chk("power", 8'h0, pwr);
        cmd(8'had);
        cmd(8'h01);
        cmd(8'ha5);
        chk("power", 8'h3, pwr);
        apb(1'b1, 12'h004, 8'h0f);
        chk("column", 8'h08, col);
        cmd(8'he2);
        chk("power", 8'h1, pwr);
        cmd(8'ha4);
        cmd(8'haf);
        chk("display on", 8'h1, dsp);
        cmd(8'ha5);
        chk("power", 8'h0, pwr);
        chk("all on", 8'h1, allon);
        cmd(8'ha4);
        chk("all on", 8'h0, allon);
    endtask
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        #1;
        t_soft_reset();
        t_settings();
        t_two_byte();
        t_rmw();
        t_power();
        stop_test();
    end
endmodule
